// ===== ioc_pkg.sv
// Shared constants, configuration layouts and types of the I/O cell block.
// Assumes a single 20 MHz system clock that samples every pin and every clock.
package ioc_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_CELLS     = 3;   // Cells in one I/O block
    localparam int NUM_IO_CLK    = 6;   // Dedicated low-skew I/O clocks
    localparam int DLY_DEPTH     = 4;   // Taps of a cell input delay chain
    localparam int DLY_SEL_W     = 2;   // Tap select width of a cell chain
    localparam int DQ_W          = 8;   // Data pins clocked by one strobe
    localparam int DQS_DLY_DEPTH = 8;   // Taps of the strobe delay chain
    localparam int DQS_SEL_W     = 3;   // Tap select width of the strobe chain

    // ==========================================================
    // Clock source selection: 0 is the cell fabric clock, n is dedicated
    // clock n-1, and the top code is the row/column routing clock
    localparam int          CLK_SEL_W      = 3;
    localparam logic [2:0]  CLK_SEL_FABRIC = 3'h0;

    // ==========================================================
    // Strobe phase shift, as degrees and as taps (90:72 is 5:4)
    localparam int          DQS_SHIFT_DDR_DEG = 90;
    localparam int          DQS_SHIFT_ALT_DEG = 72;
    localparam logic [2:0]  DQS_TAPS_DDR      = 3'h5;
    localparam logic [2:0]  DQS_TAPS_ALT      = 3'h4;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ         = 20;    // System clock rate
    localparam int MEM_CLK_MAX_MHZ = 133;   // Ceiling of the memory path

    // ==========================================================
    // Types
    typedef enum logic { MEM_DDR, MEM_ALT } ioc_mem_e;

    typedef enum logic { CAP_WAIT_RISE, CAP_WAIT_FALL } ioc_cap_e;

    // Seven fabric-driven signals of one cell
    typedef struct packed {
        logic dataout;
        logic oe;
        logic ce_in;
        logic ce_out;
        logic clk;
        logic aclr;
        logic sclr;
    } ioc_fab_s;

    // Static configuration of one cell
    typedef struct packed {
        logic [CLK_SEL_W-1:0] in_clk_sel;
        logic [CLK_SEL_W-1:0] out_clk_sel;
        logic                 in_ce_use;
        logic                 out_ce_use;
        logic                 aclr_use;
        logic                 sclr_use;
        logic                 preset_mode;
        logic                 in_reg_use;
        logic                 out_reg_use;
        logic                 oe_reg_use;
        logic                 dual_path;
        logic [DLY_SEL_W-1:0] dly_a;
        logic [DLY_SEL_W-1:0] dly_b;
    } ioc_cell_cfg_s;

    // Data returned to the fabric by one cell
    typedef struct packed {
        logic datain;
        logic comb_datain;
    } ioc_ret_s;

endpackage

// ===== ioc_sync.sv
// Two-flop synchroniser with edge detection for a vector of inputs.
// Assumes the inputs are asynchronous to clk_i; edges are found after the second flop.
`timescale 1ns/1ns
module ioc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,     // System clock
    input  wire logic         rst_n_i,   // Synchronous reset, active low
    input  wire logic [W-1:0] d_i,       // Asynchronous inputs
    output logic      [W-1:0] q_o,       // Synchronised level
    output logic      [W-1:0] rise_o,    // One-cycle rising edge
    output logic      [W-1:0] fall_o     // One-cycle falling edge
);
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] hist;

    // ==========================================================
    // Synchroniser chain and edge history
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            sync <= '0;
            hist <= '0;
        end else begin
            meta <= d_i;
            sync <= meta;
            hist <= sync;
        end
    end

    // Edges read only the second flop and its history
    assign q_o    = sync;
    assign rise_o = sync & ~hist;
    assign fall_o = ~sync & hist;

endmodule // ioc_sync

// ===== ioc_delay.sv
// Programmable delay chain: a shift line of flops with a selectable tap.
// Assumes a synchronous input; tap k delays by k+1 clock cycles.
`timescale 1ns/1ns
module ioc_delay #(
    parameter int W     = 1,
    parameter int DEPTH = 4,
    parameter int SEL_W = 2
) (
    input  wire logic             clk_i,     // System clock
    input  wire logic             rst_n_i,   // Synchronous reset, active low
    input  wire logic [W-1:0]     d_i,       // Input to delay
    input  wire logic [SEL_W-1:0] sel_i,     // Tap select
    output logic      [W-1:0]     q_o        // Delayed output
);
    logic [W-1:0] taps [DEPTH];

    // ==========================================================
    // Shift line, one stage per tap
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_tap
            if (i == 0) begin : g_first
                always_ff @(posedge clk_i) begin
                    if (!rst_n_i) taps[i] <= '0;
                    else taps[i] <= d_i;
                end
            end else begin : g_next
                always_ff @(posedge clk_i) begin
                    if (!rst_n_i) taps[i] <= '0;
                    else taps[i] <= taps[i-1];
                end
            end
        end
    endgenerate

    // Tap selection
    assign q_o = taps[sel_i];

endmodule // ioc_delay

// ===== ioc_io_block.sv
// I/O block of three programmable cells plus one byte-wide memory strobe group.
// Assumes fabric signals are on clk_i; pins and all clocks are sampled
// through two flops and their edges act as register load strobes.
`timescale 1ns/1ns

module ioc_io_block
    import ioc_pkg::*;
#(
    parameter int NUM_CELLS  = ioc_pkg::NUM_CELLS,
    parameter int NUM_IO_CLK = ioc_pkg::NUM_IO_CLK,
    parameter int DQ_W       = ioc_pkg::DQ_W
) (
    input  wire logic                                    clk_i,          // System clock, 20 MHz
    input  wire logic                                    rst_n_i,        // Synchronous reset, active low
    input  ioc_pkg::ioc_fab_s      [NUM_CELLS-1:0]       fab_i,          // Fabric data and controls
    input  wire logic              [NUM_IO_CLK-1:0]      io_clk_i,       // Dedicated I/O clocks
    input  wire logic                                    row_clk_i,      // Row/column routing clock
    input  ioc_pkg::ioc_cell_cfg_s [NUM_CELLS-1:0]       cfg_i,          // Per-cell configuration
    output ioc_pkg::ioc_ret_s      [NUM_CELLS-1:0]       ret_o,          // Data back to the fabric
    output logic                   [NUM_CELLS-1:0]       in_reg_avail_o, // Input register usable
    input  wire logic              [NUM_CELLS-1:0]       pin_i,          // Pin level in
    output logic                   [NUM_CELLS-1:0]       pin_o,          // Pin level out
    output logic                   [NUM_CELLS-1:0]       pin_oe_o,       // Pin driver enable
    input  ioc_pkg::ioc_mem_e                            mem_type_i,     // Memory type select
    input  wire logic                                    dqs_i,          // Memory strobe pin
    input  wire logic              [DQ_W-1:0]            dq_i,           // Memory data pins in
    output logic                   [DQ_W-1:0]            dq_o,           // Memory data pins out
    output logic                   [DQ_W-1:0]            dq_oe_o,        // Memory data driver enables
    output logic                                         dm_o,           // Memory data mask pin
    input  wire logic                                    pll_clk_i,      // Phase-shifted PLL clock
    input  wire logic              [DQ_W-1:0]            wr_data_i,      // Write data from fabric
    input  wire logic                                    wr_oe_i,        // Write drive enable
    input  wire logic                                    wr_dm_i,        // Write mask
    output logic                   [2*DQ_W-1:0]          rd_data_o,      // Read pair {rise, fall}
    output logic                                         rd_valid_o      // Read pair valid pulse
);

    // ==========================================================
    // Clock edge selection
    localparam int DED_W = NUM_IO_CLK + 1;

    // Edge of the chosen clock: fabric clock, or dedicated/row clock
    function automatic logic pick_edge(
        input logic [CLK_SEL_W-1:0] sel,
        input logic                 fab_rise,
        input logic [DED_W-1:0]     ded_rise
    );
        logic [CLK_SEL_W-1:0] idx;
        // Code 0 returns before the wrapped index is ever used
        idx = sel - 3'h1;
        if (sel == CLK_SEL_FABRIC) return fab_rise;
        return ded_rise[idx];
    endfunction

    logic [DED_W-1:0]     ded_rise;
    logic [NUM_CELLS-1:0] fab_clk;
    logic [NUM_CELLS-1:0] fab_rise;
    logic [NUM_CELLS-1:0] pin_s;

    // Dedicated clocks with the row clock on top
    ioc_sync #(.W(DED_W)) u_ded_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({row_clk_i, io_clk_i}),
        .q_o     (),
        .rise_o  (ded_rise),
        .fall_o  ()
    );

    // Fabric clocks of each cell
    ioc_sync #(.W(NUM_CELLS)) u_fab_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (fab_clk),
        .q_o     (),
        .rise_o  (fab_rise),
        .fall_o  ()
    );

    // Cell pins
    ioc_sync #(.W(NUM_CELLS)) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (pin_i),
        .q_o     (pin_s),
        .rise_o  (),
        .fall_o  ()
    );

    // ==========================================================
    // I/O cells
    generate
        for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
            logic in_reg;
            logic out_reg;
            logic oe_reg;
            logic path_a;
            logic path_b;

            assign fab_clk[c] = fab_i[c].clk;

            // Own clock sources for input and for output/enable registers
            wire in_edge  = pick_edge(cfg_i[c].in_clk_sel, fab_rise[c], ded_rise);
            wire out_edge = pick_edge(cfg_i[c].out_clk_sel, fab_rise[c], ded_rise);
            wire in_ce    = !cfg_i[c].in_ce_use || fab_i[c].ce_in;
            wire out_ce   = !cfg_i[c].out_ce_use || fab_i[c].ce_out;

            // One shared clear/preset source and level for all three registers
            wire aclr_act = cfg_i[c].aclr_use && fab_i[c].aclr;
            wire sclr_act = cfg_i[c].sclr_use && fab_i[c].sclr;
            wire clr_val  = cfg_i[c].preset_mode;

            // Two input delay paths; with dual_path set, differing delays take the input register away
            ioc_delay #(.W(1), .DEPTH(DLY_DEPTH), .SEL_W(DLY_SEL_W)) u_dly_a (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .d_i     (pin_s[c]),
                .sel_i   (cfg_i[c].dly_a),
                .q_o     (path_a)
            );
            ioc_delay #(.W(1), .DEPTH(DLY_DEPTH), .SEL_W(DLY_SEL_W)) u_dly_b (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .d_i     (pin_s[c]),
                .sel_i   (cfg_i[c].dly_b),
                .q_o     (path_b)
            );
            wire conflict = cfg_i[c].dual_path && (cfg_i[c].dly_a != cfg_i[c].dly_b);

            // Load strobes: async clear loads at once, else selected edge and enable
            wire in_load  = aclr_act || (in_edge && in_ce);
            wire out_load = aclr_act || (out_edge && out_ce);

            // Next values: async clear first, then sync clear, then data
            wire next_in  = (aclr_act || sclr_act) ? clr_val : path_a;
            wire next_out = (aclr_act || sclr_act) ? clr_val : fab_i[c].dataout;
            wire next_oe  = (aclr_act || sclr_act) ? clr_val : fab_i[c].oe;

            // Input register, powers up to the programmed level
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) in_reg <= clr_val;
                else if (in_load) in_reg <= next_in;
            end

            // Output and enable registers, one clock and one enable
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    out_reg <= clr_val;
                    oe_reg  <= clr_val;
                end else if (out_load) begin
                    out_reg <= next_out;
                    oe_reg  <= next_oe;
                end
            end

            // Returns to the fabric and pin drive
            assign in_reg_avail_o[c]  = !conflict;
            assign ret_o[c].datain      = (cfg_i[c].in_reg_use && !conflict) ? in_reg : path_a;
            assign ret_o[c].comb_datain = cfg_i[c].dual_path ? path_b : path_a;
            assign pin_o[c]    = cfg_i[c].out_reg_use ? out_reg : fab_i[c].dataout;
            assign pin_oe_o[c] = cfg_i[c].oe_reg_use ? oe_reg : fab_i[c].oe;
        end
    endgenerate

    // ==========================================================
    // Memory strobe group: sampling
    logic            dqs_s;
    logic            pll_rise;
    logic [DQ_W-1:0] dq_s;
    logic            dqs_dly;
    logic            dqs_prev;

    // Halves of the paired synchroniser that this group leaves unread
    logic            unused_pll_q;
    logic            unused_dqs_rise;

    // Strobe and PLL clock through the synchroniser
    ioc_sync #(.W(2)) u_mem_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({pll_clk_i, dqs_i}),
        .q_o     ({unused_pll_q, dqs_s}),
        .rise_o  ({pll_rise, unused_dqs_rise}),
        .fall_o  ()
    );

    // The eight data pins of this strobe's own group
    ioc_sync #(.W(DQ_W)) u_dq_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (dq_i),
        .q_o     (dq_s),
        .rise_o  (),
        .fall_o  ()
    );

    // Phase shift chosen by memory type
    // Tap k adds k+1 cycles behind the two synchroniser flops
    wire [DQS_SEL_W-1:0] dqs_taps = (mem_type_i == MEM_DDR) ? DQS_TAPS_DDR : DQS_TAPS_ALT;

    ioc_delay #(.W(1), .DEPTH(DQS_DLY_DEPTH), .SEL_W(DQS_SEL_W)) u_dqs_dly (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (dqs_s),
        .sel_i   (dqs_taps),
        .q_o     (dqs_dly)
    );

    // Edge history of the delayed strobe
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) dqs_prev <= 1'b0;
        else dqs_prev <= dqs_dly;
    end

    wire dqs_rise = dqs_dly && !dqs_prev;
    wire dqs_fall = !dqs_dly && dqs_prev;

    // ==========================================================
    // Memory strobe group: read capture
    ioc_cap_e        cap_state;
    ioc_cap_e        next_cap_state;
    logic [DQ_W-1:0] rise_word;
    logic [2*DQ_W-1:0] stage1;
    logic            stage1_v;

    // Pairing state: rising word first, falling word completes it
    always_comb begin
        next_cap_state = cap_state;
        unique case (cap_state)
            CAP_WAIT_RISE: begin
                if (dqs_rise) next_cap_state = CAP_WAIT_FALL;
            end
            CAP_WAIT_FALL: begin
                if (dqs_fall) next_cap_state = CAP_WAIT_RISE;
            end
        endcase
    end

    wire take_rise = (cap_state == CAP_WAIT_RISE) && dqs_rise;
    wire take_pair = (cap_state == CAP_WAIT_FALL) && dqs_fall;

    // Strobe edges load the data into capture registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cap_state <= CAP_WAIT_RISE;
            rise_word <= '0;
        end else begin
            cap_state <= next_cap_state;
            if (take_rise) rise_word <= dq_s;
        end
    end

    // Two successive stages carry the pair into the fabric domain
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stage1     <= '0;
            stage1_v   <= 1'b0;
            rd_data_o  <= '0;
            rd_valid_o <= 1'b0;
        end else begin
            stage1_v   <= take_pair;
            rd_valid_o <= stage1_v;
            if (take_pair) stage1 <= {rise_word, dq_s};
            if (stage1_v) rd_data_o <= stage1;
        end
    end

    // ==========================================================
    // Memory strobe group: write path on the shifted PLL clock
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dq_o    <= '0;
            dq_oe_o <= '0;
            dm_o    <= 1'b0;
        end else if (pll_rise) begin
            dq_o    <= wr_data_i;
            dq_oe_o <= {DQ_W{wr_oe_i}};
            dm_o    <= wr_dm_i;
        end
    end

endmodule // ioc_io_block

// ===== ioc_io_block_monitor.sv
// Port checker of the I/O block, cell 0 and the strobe group.
// Assumes the bind at the foot of this file.
`timescale 1ns/1ns
module ioc_io_block_monitor
    import ioc_pkg::*;
#(
    parameter int NUM_CELLS = 3,
    parameter int DQ_W      = 8
) (
    input  wire logic                            clk_i,          // Clock
    input  wire logic                            rst_n_i,        // Reset
    input  ioc_pkg::ioc_fab_s      [NUM_CELLS-1:0] fab_i,        // Fabric
    input  ioc_pkg::ioc_cell_cfg_s [NUM_CELLS-1:0] cfg_i,        // Config
    input  ioc_pkg::ioc_ret_s      [NUM_CELLS-1:0] ret_o,        // Return
    input  wire logic [NUM_CELLS-1:0]            in_reg_avail_o, // Usable
    input  wire logic [NUM_CELLS-1:0]            pin_oe_o,       // Enables
    input  wire logic                            dqs_i,          // Strobe
    input  wire logic                            pll_clk_i,      // PLL clock
    input  wire logic [DQ_W-1:0]                 wr_data_i,      // Write data
    input  wire logic [DQ_W-1:0]                 dq_o,           // Data out
    input  wire logic [DQ_W-1:0]                 dq_oe_o,        // Data enables
    input  wire logic [2*DQ_W-1:0]               rd_data_o,      // Read pair
    input  wire logic                            rd_valid_o      // Pair pulse
);
    logic       pll_q;
    logic       dqs_q;
    logic [3:0] since_pll;
    logic [4:0] since_fall;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // Cycle counts since a PLL rise and a strobe fall
    always_ff @(posedge clk_i) begin
        pll_q <= pll_clk_i;
        dqs_q <= dqs_i;
        if (!rst_n_i) begin
            since_pll  <= 4'hf;
            since_fall <= 5'h1f;
        end else begin
            since_pll  <= (pll_clk_i && !pll_q) ? 4'h0 : since_pll + {3'h0, since_pll != 4'hf};
            since_fall <= (dqs_q && !dqs_i) ? 5'h0 : since_fall + {4'h0, since_fall != 5'h1f};
        end
    end
    // ==========================================================
    // Assertions
    property p_avail; in_reg_avail_o[0] == !(cfg_i[0].dual_path && (cfg_i[0].dly_a != cfg_i[0].dly_b)); endproperty
    a_avail: assert property (p_avail)
        else $error("input register availability wrong");
    property p_oe_comb; !cfg_i[0].oe_reg_use |-> pin_oe_o[0] == fab_i[0].oe; endproperty
    a_oe_comb: assert property (p_oe_comb)
        else $error("pin enable does not follow fabric");
    property p_dq_oe; dq_oe_o == {DQ_W{dq_oe_o[0]}}; endproperty
    a_dq_oe: assert property (p_dq_oe)
        else $error("data enables disagree");
    property p_wr_time; $changed(dq_o) |-> since_pll inside {[4'h1:4'h5]} && dq_o == $past(wr_data_i); endproperty
    a_wr_time: assert property (p_wr_time)
        else $error("write word loaded off the PLL edge");
    property p_rd_pulse; rd_valid_o |=> !rd_valid_o; endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read pulse longer than one cycle");
    property p_rd_time; rd_valid_o |-> since_fall inside {[5'h6:5'h10]}; endproperty
    a_rd_time: assert property (p_rd_time)
        else $error("read pair not timed by delayed strobe");
    property p_rd_data; $changed(rd_data_o) |-> rd_valid_o; endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("read data moved without valid");
    property p_ce_hold; cfg_i[0].in_reg_use && cfg_i[0].in_ce_use && !cfg_i[0].aclr_use && in_reg_avail_o[0]
        && !fab_i[0].ce_in |=> $stable(ret_o[0].datain); endproperty
    a_ce_hold: assert property (p_ce_hold)
        else $error("input register loaded while disabled");
    property p_aclr; cfg_i[0].in_reg_use && cfg_i[0].aclr_use && fab_i[0].aclr && in_reg_avail_o[0]
        |=> ret_o[0].datain == $past(cfg_i[0].preset_mode); endproperty
    a_aclr: assert property (p_aclr)
        else $error("clear did not set the programmed level");
endmodule // ioc_io_block_monitor

bind ioc_io_block ioc_io_block_monitor #(.NUM_CELLS(NUM_CELLS), .DQ_W(DQ_W)) ioc_io_block_monitor_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .fab_i(fab_i), .cfg_i(cfg_i), .ret_o(ret_o),
    .in_reg_avail_o(in_reg_avail_o), .pin_oe_o(pin_oe_o), .dqs_i(dqs_i), .pll_clk_i(pll_clk_i),
    .wr_data_i(wr_data_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o)
);

// ===== ioc_mem_model.sv
// Memory-side model: one strobe and its eight data pins.
// Assumes calls from the bench; data is edge aligned with the strobe.
`timescale 1ns/1ns
module ioc_mem_model (
    input  wire logic       clk_i,  // System clock
    output logic            dqs_o,  // Strobe to the block
    output logic [7:0]      dq_o    // Data to the block
);
    // Strobe stands low outside frames
    initial begin
        dqs_o = 1'b0;
        dq_o  = 8'h00;
    end
    // One rise word and one fall word, each phase long enough to be captured
    task automatic burst(input logic [7:0] rise_w, input logic [7:0] fall_w);
        @(negedge clk_i);
        dq_o  = rise_w;
        dqs_o = 1'b1;
        repeat (10) @(negedge clk_i);
        dq_o  = fall_w;
        dqs_o = 1'b0;
    endtask
    // Released bus shows the inverse of its last value
    task automatic idle();
        dq_o = ~dq_o;
    endtask
endmodule // ioc_mem_model

// ===== tb.sv
// Self-checking bench of the I/O block.
// Assumes the memory model drives the strobe group pins.
`timescale 1ns/1ns
module tb;
    import ioc_pkg::*;
    logic                clk_i = 1'b0;
    logic                rst_n_i = 1'b0;
    ioc_fab_s      [2:0] fab = '0;
    ioc_cell_cfg_s [2:0] cfg = '0;
    ioc_ret_s      [2:0] ret;
    ioc_mem_e            mem_type = MEM_DDR;
    logic [5:0]          io_clk = '0;
    logic [2:0]          pin_i = '0;
    logic [7:0]          wr_data = '0;
    logic                row_clk = 1'b0, pll_clk = 1'b0, wr_oe = 1'b0, wr_dm = 1'b0;
    logic [2:0]          avail, pin_o, pin_oe;
    logic [7:0]          dq_o, dq_oe, mdq;
    logic                dm, mdqs, rd_valid;
    logic [15:0]         rd_data;
    int                  miscompares = 0;
    int                  compares = 0;
    // ==========================================================
    // Clock, design and memory model
    always #25 clk_i = ~clk_i;
    ioc_io_block ioc_io_block_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .fab_i(fab), .io_clk_i(io_clk), .row_clk_i(row_clk),
        .cfg_i(cfg), .ret_o(ret), .in_reg_avail_o(avail), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe), .mem_type_i(mem_type), .dqs_i(mdqs), .dq_i(mdq), .dq_o(dq_o),
        .dq_oe_o(dq_oe), .dm_o(dm), .pll_clk_i(pll_clk), .wr_data_i(wr_data), .wr_oe_i(wr_oe),
        .wr_dm_i(wr_dm), .rd_data_o(rd_data), .rd_valid_o(rd_valid)
    );
    ioc_mem_model ioc_mem_model_i (.clk_i(clk_i), .dqs_o(mdqs), .dq_o(mdq));
    // ==========================================================
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Pulses clock source sel: 0 fabric, 1..6 dedicated, 7 row
    task automatic pulse(input int sel);
        logic [7:0] src;
        src = 8'h01 << sel;
        fab[0].clk = src[0];
        io_clk = src[6:1];
        row_clk = src[7];
        cyc(4);
        fab[0].clk = 1'b0;
        io_clk = '0;
        row_clk = 1'b0;
        cyc(4);
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [23:0] wexp [3] = '{24'h0, 24'h5aff01, 24'ha50000};
        int n [2];
        cfg[0].in_reg_use = 1'b1;
        cfg[0].out_reg_use = 1'b1;
        cfg[0].oe_reg_use = 1'b1;
        cfg[0].in_ce_use = 1'b1;
        cfg[0].out_ce_use = 1'b1;
        cfg[0].out_clk_sel = 3'h7;
        fab[0].ce_in = 1'b1;
        cyc(3);
        rst_n_i = 1'b1;
        for (int s = 0; s < 8; s++) begin
            cfg[0].in_clk_sel = 3'(s);
            pin_i[0] = s[0];
            cyc(8);
            pulse(s);
            chk(24'(ret[0].datain), 24'(s[0]));
        end
        cfg[0].in_clk_sel = 3'h1;
        fab[0].dataout = 1'b1;
        fab[0].oe = 1'b1;
        fab[0].ce_out = 1'b1;
        pin_i[0] = 1'b0;
        cyc(8);
        pulse(7);
        chk({ret[0].datain, pin_o[0], pin_oe[0]}, 24'h7);
        fab[0] = '0;
        pulse(7);
        pulse(1);
        chk({ret[0].datain, pin_o[0], pin_oe[0]}, 24'h7);
        cfg[0].oe_reg_use = 1'b0;
        cyc(1);
        chk(24'(pin_oe[0]), 24'h0);
        fab[0].ce_in = 1'b1;
        fab[0].sclr = 1'b1;
        cfg[0].sclr_use = 1'b1;
        pin_i[0] = 1'b1;
        cyc(8);
        pulse(1);
        chk(24'(ret[0].datain), 24'h0);
        cfg[0].sclr_use = 1'b0;
        pulse(1);
        fab[0].ce_in = 1'b0;
        cfg[0].aclr_use = 1'b1;
        for (int p = 0; p < 2; p++) begin
            cfg[0].preset_mode = p[0];
            fab[0].aclr = 1'b1;
            cyc(2);
            chk({ret[0].datain, pin_o[0]}, {22'h0, {2{p[0]}}});
            fab[0].aclr = 1'b0;
        end
        cfg[0].dual_path = 1'b1;
        cfg[0].dly_b = 2'h1;
        pin_i[0] = 1'b0;
        cyc(8);
        chk({avail[0], ret[0].comb_datain, ret[0].datain}, 24'h0);
        cfg[0].dly_b = 2'h0;
        cyc(1);
        chk({avail[0], ret[0].datain}, 24'h3);
        for (int w = 0; w < 2; w++) begin
            wr_data = w[0] ? 8'ha5 : 8'h5a;
            wr_oe = !w[0];
            wr_dm = !w[0];
            cyc(8);
            chk({dq_o, dq_oe, 7'h0, dm}, wexp[w]);
            pll_clk = 1'b1;
            cyc(4);
            pll_clk = 1'b0;
            cyc(4);
            chk({dq_o, dq_oe, 7'h0, dm}, wexp[w+1]);
        end
        for (int m = 0; m < 2; m++) begin
            mem_type = ioc_mem_e'(m);
            ioc_mem_model_i.burst(8'h3c ^ 8'(m), 8'hc3);
            n[m] = 0;
            while (rd_valid !== 1'b1 && n[m] < 40) begin
                cyc(1);
                n[m]++;
            end
            chk(24'(rd_data), {8'h0, 8'h3c ^ 8'(m), 8'hc3});
            ioc_mem_model_i.idle();
            cyc(12);
        end
        chk(24'(n[0] - n[1]), 24'h1);
        tally_and_finish();
    end
endmodule // tb
